/* inc/tcbi_pkg.sv */
// Purpose: constants for the tape control bus interface
// Assumes: 36-bit processor words, 14 selection lines, 8 transports
// Notes: command layout and status layout are fixed here for both sides
package tcbi_pkg;
	localparam int WORD_W = 36;
	localparam int SEL_W = 14;
	localparam int UNIT_W = 3;
	// Command register field positions
	localparam int CMD_UNIT_LSB = 0;
	localparam int CMD_GO = 3;
	localparam int CMD_REV = 4;
	localparam int CMD_WRITE = 5;
	localparam int CMD_W = 6;
	localparam logic [CMD_W-1:0] CMD_RESET = 6'h00;
	// Status word field positions, upper bits read as zero
	localparam int ST_UNIT_LSB = 0;
	localparam int ST_GO = 3;
	localparam int ST_REV = 4;
	localparam int ST_WRITE = 5;
	localparam int ST_SPEED = 6;
	localparam int ST_ENDZONE = 7;
	localparam int ST_READY = 8;
	// Synchronised pin vector layout
	localparam int PIN_SEL = 0;
	localparam int PIN_CTL = 14;
	localparam int PIN_STREQ = 15;
	localparam int PIN_DATAO = 16;
	localparam int PIN_DATAI = 17;
	localparam int PIN_TIMING = 18;
	localparam int PIN_MARK = 19;
	localparam int PIN_TBIT = 20;
	localparam int PIN_SPEED = 21;
	localparam int PIN_ENDZ = 22;
	localparam int PIN_DATA = 23;
	localparam int PIN_W = 59;
	// Arbitrary default device address, set per installation
	localparam logic [SEL_W-1:0] DEV_ADDR_DEFAULT = 14'h0020;
	typedef enum logic [2:0] {
		CP_IDLE = 3'b001,
		CP_CLEAR = 3'b010,
		CP_LOAD = 3'b100
	} tcbi_cpstate_t;
endpackage

/* rtl/tcbi_bus_iface.sv */
// Purpose: bus front end of a tape control unit
// Assumes: every bus and tape input is asynchronous to mclk
// Notes: all outputs are registered; drivers are released when not addressed
`timescale 1ns/10ps
module tcbi_bus_iface #(
	parameter logic [tcbi_pkg::SEL_W-1:0] DEV_ADDR = tcbi_pkg::DEV_ADDR_DEFAULT
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [tcbi_pkg::SEL_W-1:0] busSel,
	input wire logic busCtlPulse,
	input wire logic busStatReq,
	input wire logic busDataoPulse,
	input wire logic busDataiReq,
	input wire logic [tcbi_pkg::WORD_W-1:0] busDataIn,
	output logic [tcbi_pkg::WORD_W-1:0] busDataOut,
	output logic busDataOe,
	input wire logic tapeTiming,
	input wire logic tapeMark,
	input wire logic tapeBitIn,
	input wire logic tapeUpToSpeed,
	input wire logic tapeEndZone,
	output logic [tcbi_pkg::UNIT_W-1:0] unitSel,
	output logic motionGo,
	output logic motionRev,
	output logic writeEnable,
	output logic tapeBitOut
);
	localparam int W = tcbi_pkg::WORD_W;

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchroniser for every pin; logic reads only syncB, and syncPrev for edge detection
	logic [tcbi_pkg::PIN_W-1:0] pinRaw;
	logic [tcbi_pkg::PIN_W-1:0] syncA;
	logic [tcbi_pkg::PIN_W-1:0] syncB;
	logic [tcbi_pkg::PIN_W-1:0] syncPrev;
	assign pinRaw = {busDataIn, tapeEndZone, tapeUpToSpeed, tapeBitIn,
		tapeMark, tapeTiming, busDataiReq, busDataoPulse, busStatReq,
		busCtlPulse, busSel};

	always_ff @(posedge mclk) begin
		if (rst) begin
			syncA <= '0;
			syncB <= '0;
			syncPrev <= '0;
		end else begin
			syncA <= pinRaw;
			syncB <= syncA;
			syncPrev <= syncB;
		end
	end

	// Decoded pin views
	logic addrHit;
	logic ctlEdge;
	logic dataoEdge;
	logic timingEdge;
	logic markEdge;
	logic [W-1:0] dataSync;
	assign addrHit = syncB[tcbi_pkg::PIN_SEL +: tcbi_pkg::SEL_W] == DEV_ADDR;
	assign ctlEdge = syncB[tcbi_pkg::PIN_CTL] & ~syncPrev[tcbi_pkg::PIN_CTL];
	assign dataoEdge = syncB[tcbi_pkg::PIN_DATAO]
		& ~syncPrev[tcbi_pkg::PIN_DATAO];
	assign timingEdge = syncB[tcbi_pkg::PIN_TIMING]
		& ~syncPrev[tcbi_pkg::PIN_TIMING];
	assign markEdge = syncB[tcbi_pkg::PIN_MARK] & ~syncPrev[tcbi_pkg::PIN_MARK];
	assign dataSync = syncB[tcbi_pkg::PIN_DATA +: W];

	////////////////////////////////////////////////////////////////////////
	// Command, tape and bus state
	tcbi_pkg::tcbi_cpstate_t cpState, next_cpState;
	logic [tcbi_pkg::CMD_W-1:0] cmd, next_cmd;
	logic [W-1:0] cmdData, next_cmdData;
	logic [W-1:0] bufWord, next_bufWord;
	logic [W-1:0] shiftWord, next_shiftWord;
	logic dataReady, next_dataReady;
	logic endHit, next_endHit;
	logic [W-1:0] next_busDataOut;
	logic next_busDataOe;
	logic next_tapeBitOut;
	logic [tcbi_pkg::ST_READY:0] statusWord;
	logic moving;

	// Tape moves only with go set and transport at speed
	assign moving = cmd[tcbi_pkg::CMD_GO] & syncB[tcbi_pkg::PIN_SPEED];
	assign statusWord = {dataReady, endHit, syncB[tcbi_pkg::PIN_SPEED],
		cmd[tcbi_pkg::CMD_WRITE], cmd[tcbi_pkg::CMD_REV],
		cmd[tcbi_pkg::CMD_GO], cmd[tcbi_pkg::CMD_UNIT_LSB +: tcbi_pkg::UNIT_W]};

	// Next-state logic; a set of dataReady or endHit wins over its clear in the same cycle; a go loaded in the end zone is cleared one cycle after the load
	always_comb begin
		next_cpState = cpState;
		next_cmd = cmd;
		next_cmdData = cmdData;
		next_bufWord = bufWord;
		next_shiftWord = shiftWord;
		next_dataReady = dataReady;
		next_endHit = endHit;
		next_tapeBitOut = tapeBitOut;
		next_busDataOut = '0;
		next_busDataOe = 1'b0;
		// Clear then strobe: data is captured with the pulse, loaded later
		case (cpState)
			tcbi_pkg::CP_IDLE: begin
				if (ctlEdge && addrHit) begin
					next_cmdData = dataSync;
					next_cpState = tcbi_pkg::CP_CLEAR;
				end
			end
			tcbi_pkg::CP_CLEAR: begin
				next_cmd = tcbi_pkg::CMD_RESET;
				next_endHit = 1'b0;
				next_cpState = tcbi_pkg::CP_LOAD;
			end
			tcbi_pkg::CP_LOAD: begin
				next_cmd = cmdData[tcbi_pkg::CMD_W-1:0];
				next_cpState = tcbi_pkg::CP_IDLE;
			end
			default: begin
				next_cpState = tcbi_pkg::CP_IDLE;
			end
		endcase
		// Processor writes a word into the buffer
		if (dataoEdge && addrHit) begin
			next_bufWord = dataSync;
		end
		// Processor reads: buffer is handed over, ready flag drops
		if (syncB[tcbi_pkg::PIN_DATAI] && addrHit) begin
			next_busDataOut = bufWord;
			next_busDataOe = 1'b1;
			next_dataReady = 1'b0;
		end else if (syncB[tcbi_pkg::PIN_STREQ] && addrHit) begin
			next_busDataOut = {{(W - tcbi_pkg::ST_READY - 1){1'b0}}, statusWord};
			next_busDataOe = 1'b1;
		end
		// Bit clock comes only from the timing track
		if (moving && timingEdge) begin
			if (cmd[tcbi_pkg::CMD_WRITE]) begin
				next_tapeBitOut = shiftWord[W-1];
				next_shiftWord = {shiftWord[W-2:0], 1'b0};
			end else begin
				next_shiftWord = {shiftWord[W-2:0], syncB[tcbi_pkg::PIN_TBIT]};
			end
		end
		// Word boundary comes only from the mark track
		if (moving && markEdge) begin
			if (cmd[tcbi_pkg::CMD_WRITE]) begin
				next_shiftWord = bufWord;
			end else begin
				next_bufWord = shiftWord;
				next_dataReady = 1'b1;
			end
		end
		// End zone kills motion, sticky until the next command
		if (syncB[tcbi_pkg::PIN_ENDZ] && cmd[tcbi_pkg::CMD_GO]) begin
			next_cmd[tcbi_pkg::CMD_GO] = 1'b0;
			next_endHit = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cpState <= tcbi_pkg::CP_IDLE;
			cmd <= tcbi_pkg::CMD_RESET;
			cmdData <= '0;
			bufWord <= '0;
			shiftWord <= '0;
			dataReady <= 1'b0;
			endHit <= 1'b0;
			tapeBitOut <= 1'b0;
			busDataOut <= '0;
			busDataOe <= 1'b0;
		end else begin
			cpState <= next_cpState;
			cmd <= next_cmd;
			cmdData <= next_cmdData;
			bufWord <= next_bufWord;
			shiftWord <= next_shiftWord;
			dataReady <= next_dataReady;
			endHit <= next_endHit;
			tapeBitOut <= next_tapeBitOut;
			busDataOut <= next_busDataOut;
			busDataOe <= next_busDataOe;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transport controls registered from the command; go gated by end zone
	always_ff @(posedge mclk) begin
		if (rst) begin
			unitSel <= '0;
			motionGo <= 1'b0;
			motionRev <= 1'b0;
			writeEnable <= 1'b0;
		end else begin
			unitSel <= next_cmd[tcbi_pkg::CMD_UNIT_LSB +: tcbi_pkg::UNIT_W];
			motionGo <= next_cmd[tcbi_pkg::CMD_GO];
			motionRev <= next_cmd[tcbi_pkg::CMD_REV];
			writeEnable <= next_cmd[tcbi_pkg::CMD_WRITE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_ctlTaken;
		cpState == tcbi_pkg::CP_IDLE && ctlEdge && addrHit;
	endsequence
	sequence s_clearThenLoad;
		##1 (cpState == tcbi_pkg::CP_CLEAR) ##1 (cmd == tcbi_pkg::CMD_RESET);
	endsequence

	a_clear_then_load: assert property (s_ctlTaken |-> s_clearThenLoad)
		else $error("command register not cleared before load");
	// Only the low command bits are loaded; upper bus bits are don't-care
	a_load_value: assert property (s_ctlTaken ##1 1'b1 ##1 1'b1 |=>
		cmd == $past(cmdData[tcbi_pkg::CMD_W-1:0]))
		else $error("command register not loaded with captured bits");
	a_foreign_pulse: assert property (cpState == tcbi_pkg::CP_IDLE
		&& ctlEdge && !addrHit |=> cpState == tcbi_pkg::CP_IDLE)
		else $error("control pulse taken for foreign address");
	a_status_drive: assert property (syncB[tcbi_pkg::PIN_STREQ]
		&& addrHit && !syncB[tcbi_pkg::PIN_DATAI] |=> busDataOe
		&& busDataOut[tcbi_pkg::ST_GO] == $past(cmd[tcbi_pkg::CMD_GO]))
		else $error("status not returned on request");
	a_bus_release: assert property (!addrHit |=> !busDataOe)
		else $error("bus driven while not addressed");
	a_speed_gate: assert property (!syncB[tcbi_pkg::PIN_SPEED]
		|=> $stable(shiftWord) && $stable(tapeBitOut))
		else $error("tape data moved below speed");
	a_end_stop: assert property (syncB[tcbi_pkg::PIN_ENDZ]
		&& cmd[tcbi_pkg::CMD_GO] |=> !motionGo && endHit)
		else $error("motion not stopped in end zone");
	a_timing_only: assert property (!timingEdge && !markEdge
		&& cpState != tcbi_pkg::CP_LOAD |=> $stable(shiftWord))
		else $error("shift without tape timing");
	a_unit_follow: assert property (cpState == tcbi_pkg::CP_LOAD |=>
		unitSel == $past(cmdData[tcbi_pkg::UNIT_W-1:0]))
		else $error("unit select does not follow command");
endmodule

/* verif/tcbi_tape_model.sv */
// Purpose: behavioural tape transport for the bus interface bench
// Assumes: motion starts and stops only at word boundaries
// Notes: speed comes up only after one full word of motion
`timescale 1ns/10ps
module tcbi_tape_model (
	input wire logic mclk,
	input wire logic motionGo,
	input wire logic endzReq,
	input wire logic tapeBitOut,
	output logic [35:0] wrWord,
	output logic tapeTiming,
	output logic tapeMark,
	output logic tapeBitIn,
	output logic tapeUpToSpeed,
	output logic tapeEndZone,
	output int nWords
);
	logic [35:0] word;
	assign tapeEndZone = endzReq; // End zone follows the bench
	////////////////////////////////////////////////////////////////
	// One track pulse: high 3 cycles, low 3 counting the wait for the first edge
	task automatic pulse(input logic mark);
		@(posedge mclk);
		#1;
		if (mark) tapeMark = 1'b1;
		else tapeTiming = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		{tapeMark, tapeTiming} = 2'h0;
		repeat (2) @(posedge mclk);
		#1;
		// Written bit has settled well before the next timing pulse
		if (!mark) wrWord = {wrWord[34:0], tapeBitOut};
	endtask
	// Words go MSB first, each closed by a mark pulse
	initial begin
		{tapeTiming, tapeMark, tapeBitIn, tapeUpToSpeed} = 4'h0;
		nWords = 0;
		wrWord = 36'h0;
		forever begin
			@(posedge mclk);
			#1;
			if (motionGo !== 1'b1) begin
				tapeUpToSpeed = 1'b0;
				tapeBitIn = ~tapeBitIn; // No stale level when idle
			end else begin
				word = 36'h9a5c3e1f7 ^ 36'(nWords);
				for (int i = 35; i >= 0; i--) begin
					tapeBitIn = word[i];
					pulse(1'b0);
				end
				pulse(1'b1);
				nWords++;
				tapeUpToSpeed = motionGo; // Slow start, one word late
			end
		end
	end
endmodule

/* verif/tape_control_bus_interface_bench.sv */
// Purpose: self-checking bench for the tape bus interface
// Assumes: design sync lag of 2-3 cycles on every pin
// Notes: waits are generous fixed counts past that lag
`timescale 1ns/10ps
`define CHK(a, b) begin \
	total_checks++; \
	if ((a) !== (b)) begin \
		n_fail++; \
		$display("CHECK FAILED t=%0t got %h want %h", $time, a, b); \
	end \
end
module tape_control_bus_interface_bench;
	localparam logic [13:0] DEV = tcbi_pkg::DEV_ADDR_DEFAULT;
	logic mclk, rst, busCtlPulse, busStatReq, busDataoPulse, busDataiReq;
	logic [13:0] busSel;
	logic [35:0] busDataIn, busDataOut;
	logic busDataOe, tapeTiming, tapeMark, tapeBitIn, tapeUpToSpeed;
	logic tapeEndZone, motionGo, motionRev, writeEnable, tapeBitOut;
	logic endzReq, expEnd, expReady;
	logic [2:0] unitSel;
	logic [5:0] expCmd;
	logic [15:0] lfsrState;
	logic [35:0] wrWord;
	logic [35:0] bufQ[$];
	int nWords, n_fail, total_checks, cycles, n0;
	tcbi_bus_iface dut_u (.mclk(mclk), .rst(rst), .busSel(busSel),
		.busCtlPulse(busCtlPulse), .busStatReq(busStatReq),
		.busDataoPulse(busDataoPulse), .busDataiReq(busDataiReq),
		.busDataIn(busDataIn), .busDataOut(busDataOut),
		.busDataOe(busDataOe), .tapeTiming(tapeTiming), .tapeMark(tapeMark),
		.tapeBitIn(tapeBitIn), .tapeUpToSpeed(tapeUpToSpeed),
		.tapeEndZone(tapeEndZone), .unitSel(unitSel), .motionGo(motionGo),
		.motionRev(motionRev), .writeEnable(writeEnable),
		.tapeBitOut(tapeBitOut));
	tcbi_tape_model tape_u (.mclk(mclk), .motionGo(motionGo),
		.endzReq(endzReq), .tapeTiming(tapeTiming), .tapeMark(tapeMark),
		.tapeBitIn(tapeBitIn), .tapeUpToSpeed(tapeUpToSpeed),
		.tapeEndZone(tapeEndZone), .tapeBitOut(tapeBitOut),
		.wrWord(wrWord), .nWords(nWords));
	////////////////////////////////////////////////////////////////
	// Clock and a hang limit far past the expected run
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			test_done();
		end
	end
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Speed is read live from the transport side
	function automatic logic [35:0] expStat();
		return {27'h0, expReady, expEnd, tapeUpToSpeed, expCmd};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic ctl(input logic [5:0] c, input logic [13:0] sel);
		lfsrState = lfsrNext(lfsrState);
		busSel = sel;
		busDataIn = {lfsrState, 14'h0, c};
		busCtlPulse = 1'b1;
		tick(3);
		busCtlPulse = 1'b0;
		tick(5);
		if (sel == DEV) begin
			expCmd = c;
			expEnd = 1'b0;
		end
		`CHK({writeEnable, motionRev, motionGo, unitSel}, expCmd)
	endtask
	task automatic stat(input logic [13:0] sel);
		busSel = sel;
		busStatReq = 1'b1;
		tick(4);
		`CHK(busDataOe, sel == DEV)
		`CHK(busDataOut, (sel == DEV) ? expStat() : 36'h0)
		busStatReq = 1'b0;
		tick(4);
		`CHK(busDataOe, 1'b0)
	endtask
	task automatic rdData(input logic [13:0] sel, input logic [35:0] w);
		busSel = sel;
		busDataiReq = 1'b1;
		tick(4);
		`CHK(busDataOe, sel == DEV)
		if (sel == DEV) `CHK(busDataOut, w)
		busDataiReq = 1'b0;
		if (sel == DEV) expReady = 1'b0;
		tick(4);
	endtask
	task automatic waitWord(input int n);
		for (int k = 0; k < 400 && nWords < n; k++) tick(1);
		`CHK(nWords >= n, 1'b1)
	endtask
	// Processor word into the buffer; the queue keeps what was sent
	task automatic dataOut(input logic [35:0] w);
		busSel = DEV;
		busDataIn = w;
		busDataoPulse = 1'b1;
		tick(3);
		busDataoPulse = 1'b0;
		tick(4);
		bufQ.push_back(w);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{busCtlPulse, busStatReq, busDataoPulse, busDataiReq, endzReq} = 5'h0;
		{busSel, busDataIn, expCmd, expEnd, expReady} = '0;
		{n_fail, total_checks, cycles} = 0;
		lfsrState = 16'h0e0d;
		rst = 1'b1;
		tick(16);
		rst = 1'b0;
		tick(2);
		`CHK({busDataOe, unitSel, motionGo, motionRev, writeEnable}, 7'h0)
		for (int u = 0; u < 8; u++) ctl({lfsrState[5:3], 3'(u)}, DEV);
		ctl(6'h13, DEV);
		ctl(6'h2d, DEV ^ 14'h0001);
		ctl(6'h2d, DEV ^ 14'h2000);
		tick(250); // Let the transport settle at rest
		stat(DEV);
		stat(DEV ^ 14'h0100);
		// Word over the bus both ways; select must be ours first
		dataOut(36'h5c3a50f1e);
		rdData(DEV, bufQ[$]);
		rdData(DEV ^ 14'h0400, 36'h0);
		// First word is lost while the tape speeds up
		ctl(6'h0a, DEV);
		n0 = nWords;
		waitWord(n0 + 1);
		tick(6);
		stat(DEV);
		waitWord(n0 + 2);
		tick(6);
		expReady = 1'b1;
		stat(DEV);
		rdData(DEV, 36'h9a5c3e1f7 ^ 36'(n0 + 1));
		// End zone stops motion and latches its status bit
		endzReq = 1'b1;
		tick(8);
		expCmd[3] = 1'b0;
		expEnd = 1'b1;
		`CHK(motionGo, 1'b0)
		stat(DEV);
		endzReq = 1'b0;
		ctl(6'h27, DEV);
		stat(DEV);
		// Buffered word goes to tape once a mark reloads the shifter
		dataOut(36'h3c96a5e01);
		ctl(6'h2c, DEV);
		n0 = nWords;
		for (int k = 1; k <= 3; k++) waitWord(n0 + k);
		`CHK(wrWord, bufQ[$])
		test_done();
	end
endmodule
